//--- reader_sync_controller.sv
`timescale 1ns/10ps
`default_nettype none
`include "reader_sync_params.svh"

module reader_sync_controller #(
	parameter int DATA_W = 64,
	parameter int BACKOFF_W = 16
) (
	// clock and reset
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic CE,
	// configuration
	input wire reader_sync_pkg::sync_mode_type SYNC_MODE,
	input wire logic CARRIER_SYNC_EN,
	input wire logic CPS_SLAVE_SEL,
	input wire logic [BACKOFF_W-1:0] BACKOFF_CYCLES,
	input wire logic RUN,
	// receiver noise comparator, asynchronous
	input wire logic NOISE_DETECT,
	// radio module
	output logic RADIO_START,
	output var reader_sync_pkg::op_type RADIO_OP,
	input wire logic RADIO_DONE,
	input wire logic [DATA_W-1:0] RADIO_DATA,
	// status and result buffer
	output logic CMD_REJECT,
	output logic CONFIG_ERROR,
	output logic CPS_SLAVE,
	output logic BACKOFF_ACTIVE,
	output logic RESULT_VALID,
	output logic [DATA_W-1:0] RESULT_DATA,
	input wire logic RESULT_TAKE,
	// synchronization bus
	sync_bus_if.reader BUS
);
	import reader_sync_pkg::*;

	// ------------------------------------------------------------
	// pin filters
	// ------------------------------------------------------------
	logic noise_f;
	logic pulse_f;
	logic ack_f;
	logic busy_f;

	pin_filter #(.RESET_LEVEL(`LINE_IDLE_LOW)) u_noise (
		.clk(CLK), .arst_n(ARST_N), .ce(CE),
		.pin(NOISE_DETECT), .level(noise_f)
	);
	pin_filter #(.RESET_LEVEL(`LINE_IDLE_LOW)) u_pulse (
		.clk(CLK), .arst_n(ARST_N), .ce(CE),
		.pin(BUS.sync_line), .level(pulse_f)
	);
	pin_filter #(.RESET_LEVEL(`LINE_IDLE_HIGH)) u_ack (
		.clk(CLK), .arst_n(ARST_N), .ce(CE),
		.pin(BUS.ack_line), .level(ack_f)
	);
	pin_filter #(.RESET_LEVEL(`LINE_IDLE_HIGH)) u_busy (
		.clk(CLK), .arst_n(ARST_N), .ce(CE),
		.pin(BUS.busy_line), .level(busy_f)
	);

	// ------------------------------------------------------------
	// mode decode
	// ------------------------------------------------------------
	reader_state_type state;
	reader_state_type next_state;
	logic [BACKOFF_W-1:0] backoff;
	logic [3:0] echo;
	logic [3:0] settle;
	logic [2:0] pulse_cnt;
	logic pulse_d;
	logic pending;
	op_type op_hold;
	logic config_bad;
	logic use_noise;
	logic use_wire;
	logic sense_mode;
	logic pulse_rise;
	logic foreign;
	logic request;
	logic go;
	logic cmd_ok;

	assign config_bad = (SYNC_MODE == SYNC_TRIGGERED) && CARRIER_SYNC_EN;
	assign use_noise = (SYNC_MODE == SYNC_WIRELESS) ||
		(SYNC_MODE == SYNC_COMBINED);
	assign use_wire = (SYNC_MODE == SYNC_WIRED) ||
		(SYNC_MODE == SYNC_COMBINED);
	assign sense_mode = use_noise || use_wire;
	assign pulse_rise = pulse_f && !pulse_d;
	assign request = pending || RUN;

	// own field and own bus drive echo back; mask them for a while
	assign foreign = (use_noise && noise_f && echo == 4'h0) ||
		(use_wire && !busy_f && echo == 4'h0);

	// sense modes take only charge-only reads
	assign cmd_ok = !sense_mode || BUS.cmd_op == OP_CHARGE_READ;

	// ------------------------------------------------------------
	// start permission per mode
	// ------------------------------------------------------------
	always_comb begin
		case (SYNC_MODE)
			SYNC_NONE: go = 1'b1;
			SYNC_WIRELESS, SYNC_WIRED, SYNC_COMBINED:
				go = backoff == '0 && !foreign;
			SYNC_MS_MASTER: go = 1'b1;
			SYNC_MS_MASTER_ACK: go = ack_f && settle == 4'h0;
			SYNC_MS_SLAVE, SYNC_MS_SLAVE_ACK:
				go = pulse_rise;
			SYNC_TRIGGERED: go = pulse_rise && !config_bad;
			default: go = 1'b0;
		endcase
	end

	// cycle sequencing
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (request) begin
					next_state = ST_ARM;
				end
			end
			ST_ARM: begin
				if (!request) begin
					next_state = ST_IDLE;
				end else if (go) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (RADIO_DONE) begin
					next_state = ST_DONE;
				end
			end
			ST_DONE: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state <= ST_IDLE;
		end else if (CE) begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------
	// command intake
	// ------------------------------------------------------------
	// a command taken in the start cycle keeps pending set
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			pending <= 1'b0;
			op_hold <= OP_CHARGE_READ;
			CMD_REJECT <= 1'b0;
		end else if (CE) begin
			CMD_REJECT <= BUS.cmd_valid && !cmd_ok;
			if (BUS.cmd_valid && cmd_ok) begin
				pending <= 1'b1;
				op_hold <= BUS.cmd_op;
			end else if (state == ST_ARM && go) begin
				pending <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// back-off and echo masking
	// ------------------------------------------------------------
	// reload on every indication so the quiet time restarts
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			backoff <= `BACKOFF_RESET;
		end else if (CE) begin
			if (foreign) begin
				backoff <= BACKOFF_CYCLES;
			end else if (backoff != '0) begin
				backoff <= backoff - 1'b1;
			end
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			echo <= 4'h0;
		end else if (CE) begin
			if (state == ST_RUN || BUS.busy_oe) begin
				echo <= 4'(`ECHO_CYCLES);
			end else if (echo != 4'h0) begin
				echo <= echo - 4'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// bus drive
	// ------------------------------------------------------------
	// master pulse lasts long enough to pass the slaves' pin filters
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			BUS.lead_pulse <= 1'b0;
			pulse_cnt <= 3'h0;
			settle <= 4'h0;
			pulse_d <= 1'b0;
		end else if (CE) begin
			pulse_d <= pulse_f;
			if (state == ST_ARM && go && (SYNC_MODE == SYNC_MS_MASTER ||
				SYNC_MODE == SYNC_MS_MASTER_ACK)) begin
				BUS.lead_pulse <= 1'b1;
				pulse_cnt <= 3'(`PULSE_CYCLES - 1);
				settle <= 4'(`ACK_SETTLE_CYCLES);
			end else begin
				if (pulse_cnt != 3'h0) begin
					pulse_cnt <= pulse_cnt - 3'h1;
				end else begin
					BUS.lead_pulse <= 1'b0;
				end
				if (settle != 4'h0) begin
					settle <= settle - 4'h1;
				end
			end
		end
	end

	// acked slave holds the ack line low through its own cycle
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			BUS.ack_o <= 1'b0;
			BUS.ack_oe <= 1'b0;
			BUS.busy_o <= 1'b0;
			BUS.busy_oe <= 1'b0;
		end else if (CE) begin
			BUS.ack_oe <= SYNC_MODE == SYNC_MS_SLAVE_ACK &&
				next_state == ST_RUN;
			BUS.busy_oe <= use_wire && next_state == ST_RUN;
		end
	end

	// ------------------------------------------------------------
	// radio control and result buffer
	// ------------------------------------------------------------
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			RADIO_START <= 1'b0;
			RADIO_OP <= OP_CHARGE_READ;
		end else if (CE) begin
			RADIO_START <= state == ST_ARM && go;
			if (state == ST_ARM && go) begin
				RADIO_OP <= op_hold;
			end
		end
	end

	// a new result wins over a take in the same cycle
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			RESULT_VALID <= 1'b0;
			RESULT_DATA <= '0;
		end else if (CE) begin
			if (state == ST_RUN && RADIO_DONE) begin
				RESULT_VALID <= 1'b1;
				RESULT_DATA <= RADIO_DATA;
			end else if (RESULT_TAKE) begin
				RESULT_VALID <= 1'b0;
			end
		end
	end

	// status mirrors
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			CONFIG_ERROR <= 1'b0;
			CPS_SLAVE <= 1'b0;
			BACKOFF_ACTIVE <= 1'b0;
		end else if (CE) begin
			CONFIG_ERROR <= config_bad;
			CPS_SLAVE <= CPS_SLAVE_SEL;
			BACKOFF_ACTIVE <= backoff != '0;
		end
	end

endmodule

`default_nettype wire

//--- reader_sync_params.svh
`ifndef READER_SYNC_PARAMS_SVH
`define READER_SYNC_PARAMS_SVH

// ------------------------------------------------------------
// clock and timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define NS_PER_MS 1000000
`define READ_WINDOW_MS 90
`define WRITE_WINDOW_MS 320
// window lengths in clock cycles; integer division rounds down
`define READ_WINDOW_CYCLES (`READ_WINDOW_MS * `NS_PER_MS / `CLK_PERIOD_NS)
`define WRITE_WINDOW_CYCLES (`WRITE_WINDOW_MS * `NS_PER_MS / `CLK_PERIOD_NS)
// a bus pulse must outlast the three-stage pin filter
`define PULSE_CYCLES 4
// master waits this long after its pulse before trusting the ack line
`define ACK_SETTLE_CYCLES 8
// own bus drive and own field echo back through the pin filter this long
`define ECHO_CYCLES 4

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define BACKOFF_RESET 16'h0000
`define LINE_IDLE_HIGH 1'b1
`define LINE_IDLE_LOW 1'b0

`endif

//--- reader_sync_pkg.sv
package reader_sync_pkg;

	// synchronization modes
	typedef enum logic [2:0] {
		MODE_NONE = 3'h0,
		MODE_WIRELESS = 3'h1,
		MODE_WIRED = 3'h2,
		MODE_COMBINED = 3'h3,
		MODE_MS_MASTER = 3'h4,
		MODE_MS_SLAVE = 3'h5,
		MODE_MS_MASTER_ACK = 3'h6,
		MODE_MS_SLAVE_ACK = 3'h7
	} sync_mode_core_type;

	typedef logic [3:0] sync_mode_type;

	// mode codes as full four-bit values; only 4'h8 selects triggered
	localparam sync_mode_type SYNC_NONE = 4'h0;
	localparam sync_mode_type SYNC_WIRELESS = 4'h1;
	localparam sync_mode_type SYNC_WIRED = 4'h2;
	localparam sync_mode_type SYNC_COMBINED = 4'h3;
	localparam sync_mode_type SYNC_MS_MASTER = 4'h4;
	localparam sync_mode_type SYNC_MS_SLAVE = 4'h5;
	localparam sync_mode_type SYNC_MS_MASTER_ACK = 4'h6;
	localparam sync_mode_type SYNC_MS_SLAVE_ACK = 4'h7;
	localparam sync_mode_type SYNC_TRIGGERED = 4'h8;

	// radio operations
	typedef enum logic [1:0] {
		OP_CHARGE_READ = 2'h0,
		OP_GENERAL_READ = 2'h1,
		OP_PROGRAM_PAGE = 2'h2,
		OP_LOCK_PAGE = 2'h3
	} op_type;

	// reader cycle states, gray along idle-arm-run-done
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_ARM = 2'h1,
		ST_RUN = 2'h3,
		ST_DONE = 2'h2
	} reader_state_type;

	// trigger source states, gray along the usual path
	typedef enum logic [2:0] {
		SRC_IDLE = 3'h0,
		SRC_CMD_RD = 3'h1,
		SRC_WIN_RD = 3'h3,
		SRC_CMD_WR = 3'h2,
		SRC_WIN_WR = 3'h6,
		SRC_ACK = 3'h7
	} source_state_type;

endpackage

//--- sync_bus_if.sv
`timescale 1ns/10ps
`default_nettype none

interface sync_bus_if;
	import reader_sync_pkg::*;

	// host command path, carried ahead of the pulse that uses it
	logic cmd_valid;
	op_type cmd_op;
	logic cmd_broadcast;

	// pulse pair: trigger source and reader-as-master
	logic trig_pulse;
	logic lead_pulse;
	logic sync_line;

	// open-drain ack line, acked slaves pull low while busy
	logic ack_o;
	logic ack_oe;
	logic ack_line;

	// open-drain wired busy line
	logic busy_o;
	logic busy_oe;
	logic busy_line;

	// wire levels worked out from the drives
	assign sync_line = trig_pulse | lead_pulse;
	assign ack_line = ack_oe ? ack_o : 1'b1;
	assign busy_line = busy_oe ? busy_o : 1'b1;

	modport reader (
		input cmd_valid, cmd_op, cmd_broadcast, sync_line, ack_line,
		input busy_line,
		output lead_pulse, ack_o, ack_oe, busy_o, busy_oe
	);

	modport source (
		output cmd_valid, cmd_op, cmd_broadcast, trig_pulse,
		input ack_line
	);

endinterface

`default_nettype wire

//--- pin_filter.sv
`timescale 1ns/10ps
`default_nettype none

module pin_filter #(
	parameter logic RESET_LEVEL = 1'b0
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	// pin and filtered level
	input wire logic pin,
	output logic level
);
	logic s1;
	logic s2;
	logic s3;

	// three stages; s1 feeds only s2 so metastability stays contained
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s1 <= RESET_LEVEL;
			s2 <= RESET_LEVEL;
			s3 <= RESET_LEVEL;
		end else if (ce) begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// accept a change only once the last two stages agree
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			level <= RESET_LEVEL;
		end else if (ce && s2 == s3) begin
			level <= s3;
		end
	end

endmodule

`default_nettype wire

//--- sync_source.sv
`timescale 1ns/10ps
`default_nettype none
`include "reader_sync_params.svh"

module sync_source #(
	parameter int READ_WINDOW = `READ_WINDOW_CYCLES,
	parameter int WRITE_WINDOW = `WRITE_WINDOW_CYCLES
) (
	// clock and reset
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic CE,
	// control
	input wire logic SRC_ENABLE,
	input wire logic WRITE_BACK,
	input wire logic WAIT_ACK,
	input wire logic BROADCAST,
	input wire reader_sync_pkg::op_type READ_OP,
	input wire reader_sync_pkg::op_type WRITE_OP,
	// status
	output logic WINDOW_READ,
	output logic WINDOW_WRITE,
	// synchronization bus
	sync_bus_if.source BUS
);
	import reader_sync_pkg::*;

	source_state_type state;
	logic [31:0] win_cnt;
	logic [2:0] pulse_cnt;
	logic ack_f;

	pin_filter #(.RESET_LEVEL(`LINE_IDLE_HIGH)) u_ack (
		.clk(CLK), .arst_n(ARST_N), .ce(CE),
		.pin(BUS.ack_line), .level(ack_f)
	);

	// ------------------------------------------------------------
	// window sequencer
	// ------------------------------------------------------------
	// the command goes out one cycle ahead of the pulse that opens
	// its window, so every reader holds it before the pulse arrives
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state <= SRC_IDLE;
			win_cnt <= 32'h0;
			BUS.cmd_valid <= 1'b0;
			BUS.cmd_op <= OP_CHARGE_READ;
			BUS.cmd_broadcast <= 1'b0;
			WINDOW_READ <= 1'b0;
			WINDOW_WRITE <= 1'b0;
		end else if (CE) begin
			BUS.cmd_valid <= 1'b0;
			BUS.cmd_broadcast <= 1'b0;
			case (state)
				SRC_IDLE: begin
					if (BROADCAST) begin
						BUS.cmd_valid <= 1'b1;
						BUS.cmd_broadcast <= 1'b1;
						BUS.cmd_op <= READ_OP;
					end else if (SRC_ENABLE) begin
						BUS.cmd_valid <= 1'b1;
						BUS.cmd_op <= READ_OP;
						state <= SRC_CMD_RD;
					end
				end
				SRC_CMD_RD: begin
					win_cnt <= 32'(READ_WINDOW - 1);
					WINDOW_READ <= 1'b1;
					state <= SRC_WIN_RD;
				end
				SRC_WIN_RD: begin
					if (win_cnt != 32'h0) begin
						win_cnt <= win_cnt - 32'h1;
					end else begin
						WINDOW_READ <= 1'b0;
						if (WRITE_BACK) begin
							BUS.cmd_valid <= 1'b1;
							BUS.cmd_op <= WRITE_OP;
							state <= SRC_CMD_WR;
						end else begin
							state <= SRC_ACK;
						end
					end
				end
				SRC_CMD_WR: begin
					win_cnt <= 32'(WRITE_WINDOW - 1);
					WINDOW_WRITE <= 1'b1;
					state <= SRC_WIN_WR;
				end
				SRC_WIN_WR: begin
					if (win_cnt != 32'h0) begin
						win_cnt <= win_cnt - 32'h1;
					end else begin
						WINDOW_WRITE <= 1'b0;
						state <= SRC_ACK;
					end
				end
				SRC_ACK: begin
					if (!WAIT_ACK || ack_f) begin
						state <= SRC_IDLE;
					end
				end
				default: state <= SRC_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// trigger pulse
	// ------------------------------------------------------------
	// single pulse source for every reader; lasts past the pin filters
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			BUS.trig_pulse <= 1'b0;
			pulse_cnt <= 3'h0;
		end else if (CE) begin
			if (state == SRC_CMD_RD || state == SRC_CMD_WR) begin
				BUS.trig_pulse <= 1'b1;
				pulse_cnt <= 3'(`PULSE_CYCLES - 1);
			end else if (pulse_cnt != 3'h0) begin
				pulse_cnt <= pulse_cnt - 3'h1;
			end else begin
				BUS.trig_pulse <= 1'b0;
			end
		end
	end

endmodule

`default_nettype wire

//--- reader_sync_assertions.sv
`timescale 1ns/10ps
`default_nettype none
`include "reader_sync_params.svh"

module reader_sync_assertions #(
	parameter int READ_WINDOW = `READ_WINDOW_CYCLES
) (
	// clock and reset
	input wire logic CLK,
	input wire logic ARST_N,
	// command and pulse lines
	input wire logic cmd_valid,
	input wire logic cmd_broadcast,
	input wire logic trig_pulse,
	input wire logic lead_pulse,
	// open-drain drives
	input wire logic ack_o,
	input wire logic ack_oe,
	input wire logic busy_o,
	input wire logic busy_oe
);
	// cap stays above any real read window length
	localparam int GAP_MAX = 32'h40000000;
	int gap;
	logic trig_prev;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!ARST_N);

	// ------------------------------------------------------------
	// helper: cycles since the last trigger rise, saturating
	// ------------------------------------------------------------
	// starts large so the first pulse after reset is never flagged
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			gap <= GAP_MAX;
			trig_prev <= 1'b0;
		end else begin
			trig_prev <= trig_pulse;
			gap <= (trig_pulse && !trig_prev) ? 1 :
				(gap < GAP_MAX ? gap + 1 : gap);
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_trig_width: assert property ($rose(trig_pulse) |->
		trig_pulse [*4] ##1 !trig_pulse)
		else $error("trigger pulse width wrong");
	a_lead_width: assert property ($rose(lead_pulse) |=>
		lead_pulse [*3] ##1 !lead_pulse)
		else $error("lead pulse width wrong");
	a_cmd_ahead: assert property ($rose(trig_pulse) |->
		$past(cmd_valid))
		else $error("window pulse without command ahead");
	a_cmd_single: assert property (cmd_valid |=> !cmd_valid)
		else $error("command held past one cycle");
	a_bcast_valid: assert property (cmd_broadcast |-> cmd_valid)
		else $error("broadcast without command valid");
	a_ack_low: assert property (ack_oe |-> !ack_o && !lead_pulse)
		else $error("ack line driven high or by the leader");
	a_busy_low: assert property (busy_oe |-> !busy_o && !ack_oe)
		else $error("busy line driven high or with ack");
	a_read_gap: assert property ($rose(trig_pulse) |->
		gap > READ_WINDOW)
		else $error("window pulse before read window ended");
	a_one_source: assert property (!(trig_pulse && lead_pulse))
		else $error("two pulse sources at once");

	// ------------------------------------------------------------
	// covers
	// ------------------------------------------------------------
	c_trig: cover property ($rose(trig_pulse));
	c_lead: cover property ($rose(lead_pulse));
	c_bcast: cover property (cmd_broadcast);
	c_ack: cover property ($rose(ack_oe));
endmodule

`default_nettype wire

//--- tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	import reader_sync_pkg::*;
	logic clk, arst_n, ce, csync, cps_sel, run, noise, rdone, take;
	logic src_en, wb, wack, bcast, rstart, rej, cfgerr, carrier_phase_sync_bus, boff;
	logic rvalid, wrd, wwr;
	logic [5:0] flags;
	logic [15:0] bk;
	logic [63:0] rdata, res;
	sync_mode_type mode;
	op_type rop, wop, op_o;
	int bad_count, compares, n, m, dly;
	sync_mode_type sense[3] = '{SYNC_WIRELESS, SYNC_COMBINED, SYNC_WIRED};
	sync_mode_type halt[3] = '{SYNC_MS_SLAVE, SYNC_MS_SLAVE_ACK,
		SYNC_TRIGGERED};

	sync_bus_if i_sync_bus_if ();
	// 5 start, 4 result, 3 reject, 2 read win, 1 write win, 0 lead
	assign flags = {rstart, rvalid, rej, wrd, wwr, i_sync_bus_if.lead_pulse};

	reader_sync_controller i_reader_sync_controller (.CLK(clk),
		.ARST_N(arst_n), .CE(ce), .SYNC_MODE(mode), .CARRIER_SYNC_EN(csync),
		.CPS_SLAVE_SEL(cps_sel), .BACKOFF_CYCLES(bk), .RUN(run),
		.NOISE_DETECT(noise), .RADIO_START(rstart), .RADIO_OP(op_o),
		.RADIO_DONE(rdone), .RADIO_DATA(rdata), .CMD_REJECT(rej),
		.CONFIG_ERROR(cfgerr), .CPS_SLAVE(carrier_phase_sync_bus), .BACKOFF_ACTIVE(boff),
		.RESULT_VALID(rvalid), .RESULT_DATA(res), .RESULT_TAKE(take),
		.BUS(i_sync_bus_if));
	// short windows keep the run brief
	sync_source #(.READ_WINDOW(20), .WRITE_WINDOW(40)) i_sync_source (
		.CLK(clk), .ARST_N(arst_n), .CE(ce), .SRC_ENABLE(src_en),
		.WRITE_BACK(wb), .WAIT_ACK(wack), .BROADCAST(bcast), .READ_OP(rop),
		.WRITE_OP(wop), .WINDOW_READ(wrd), .WINDOW_WRITE(wwr),
		.BUS(i_sync_bus_if));
	reader_sync_assertions #(.READ_WINDOW(20)) i_reader_sync_assertions (
		.CLK(clk), .ARST_N(arst_n),
		.cmd_valid(i_sync_bus_if.cmd_valid),
		.cmd_broadcast(i_sync_bus_if.cmd_broadcast),
		.trig_pulse(i_sync_bus_if.trig_pulse),
		.lead_pulse(i_sync_bus_if.lead_pulse),
		.ack_o(i_sync_bus_if.ack_o), .ack_oe(i_sync_bus_if.ack_oe),
		.busy_o(i_sync_bus_if.busy_o), .busy_oe(i_sync_bus_if.busy_oe));

	// ------------------------------------------------------------
	// clock and radio stand-in
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// finishes four cycles after each start, like a quick tag read
	always @(posedge clk) begin
		rdone <= (dly == 1);
		dly <= rstart ? 3 : (dly > 0 ? dly - 1 : 0);
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task summarize;
		$display("bad_count %0d compares %0d", bad_count, compares);
		if (bad_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task ck(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	// bounded wait; a required flag that never comes ends the run
	task wt(input int i, input logic v, input int lim, input bit must);
		n = 0;
		while (flags[i] !== v && n < lim) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (must && flags[i] !== v) begin
			bad_count++;
			$display("mismatch at %0t flag %0h exp %0h", $time, i, v);
			summarize();
		end
	endtask
	task bcast_once;
		@(posedge clk);
		bcast <= 1'b1;
		@(posedge clk);
		bcast <= 1'b0;
		#1;
	endtask
	task window(input logic wait_ack);
		@(posedge clk);
		src_en <= 1'b1;
		wack <= wait_ack;
		#1;
		wt(2, 1'b1, 10, 1);
		@(posedge clk);
		src_en <= 1'b0;
		#1;
	endtask
	task drain;
		wt(4, 1'b1, 20, 1);
		@(posedge clk);
		take <= 1'b1;
		@(posedge clk);
		take <= 1'b0;
		#1;
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{arst_n, csync, cps_sel, run, noise, take, src_en} = '0;
		{wb, wack, bcast, bad_count, compares} = '0;
		ce = 1'b1;
		mode = SYNC_NONE;
		rop = OP_CHARGE_READ;
		wop = OP_PROGRAM_PAGE;
		bk = 16'h000a;
		rdata = 64'h0123456789abcdef;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		#1;
		ck({rstart, cfgerr, rvalid, boff}, 4'h0);
		// broadcast read with no sync, result buffered
		bcast_once();
		wt(5, 1'b1, 10, 1);
		ck(op_o, OP_CHARGE_READ);
		wt(4, 1'b1, 20, 1);
		ck(res, rdata);
		drain();
		ck(rvalid, 1'b0);
		// anything but a charge read is refused in sense modes
		for (m = 1; m < 4; m++)
			for (int o = 1; o < 4; o++) begin
				@(posedge clk);
				mode <= m[3:0];
				rop <= op_type'(o);
				bcast_once();
				wt(3, 1'b1, 6, 1);
				ck(flags[3], 1'b1);
				wt(5, 1'b1, 20, 0);
				ck(n, 20);
			end
		// noise defers the cycle by the back-off count; wired modes drive busy
		foreach (sense[k]) begin
			@(posedge clk);
			mode <= sense[k];
			rop <= OP_CHARGE_READ;
			noise <= (k < 2);
			bcast_once();
			if (k < 2) begin
				wt(5, 1'b1, 40, 0);
				ck(n, 40);
				ck(boff, 1'b1);
				@(posedge clk);
				noise <= 1'b0;
				#1;
			end
			wt(5, 1'b1, 40, 1);
			if (k < 2)
				ck(n >= 10, 1'b1);
			@(posedge clk);
			#1;
			if (k > 0)
				ck(i_sync_bus_if.busy_oe, 1'b1);
			drain();
		end
		// followers start nothing without a pulse
		foreach (halt[k]) begin
			@(posedge clk);
			mode <= halt[k];
			run <= 1'b1;
			#1;
			wt(5, 1'b1, 50, 0);
			ck(n, 50);
		end
		@(posedge clk);
		run <= 1'b0;
		rop <= OP_GENERAL_READ;
		wb <= 1'b1;
		// timing bus: read window then write window
		window(1'b0);
		wt(5, 1'b1, 15, 1);
		m = n + 1;
		ck(op_o, OP_GENERAL_READ);
		wt(2, 1'b0, 30, 1);
		ck(m + n, 20);
		wt(1, 1'b1, 5, 1);
		wt(5, 1'b1, 15, 1);
		m = n;
		ck(op_o, OP_PROGRAM_PAGE);
		wt(1, 1'b0, 50, 1);
		ck(m + n, 40);
		// triggered together with carrier sync never starts
		@(posedge clk);
		csync <= 1'b1;
		wb <= 1'b0;
		window(1'b0);
		ck(cfgerr, 1'b1);
		wt(5, 1'b1, 30, 0);
		ck(n, 30);
		@(posedge clk);
		csync <= 1'b0;
		// followers start on the pulse; only the acked one holds ack
		for (m = 5; m < 8; m += 2) begin
			@(posedge clk);
			mode <= m[3:0];
			rop <= op_type'(m - 5);
			window(m[1]);
			wt(5, 1'b1, 15, 1);
			ck(op_o, m - 5);
			@(posedge clk);
			#1;
			ck(i_sync_bus_if.ack_oe, m[1]);
			repeat (60) @(posedge clk);
		end
		// carrier phase role follows its select
		cps_sel <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		ck(carrier_phase_sync_bus, 1'b1);
		// a low enable freezes every register, status mirrors too
		@(posedge clk);
		ce <= 1'b0;
		cps_sel <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		ck(carrier_phase_sync_bus, 1'b1);
		@(posedge clk);
		ce <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		ck(carrier_phase_sync_bus, 1'b0);
		// leaders pulse and start themselves
		for (m = 4; m < 7; m += 2) begin
			@(posedge clk);
			mode <= m[3:0];
			run <= 1'b1;
			#1;
			wt(0, 1'b1, 40, 1);
			wt(5, 1'b1, 15, 1);
			ck(flags[5], 1'b1);
			// with run held the acked leader restarts only after settling
			wt(5, 1'b0, 5, 1);
			wt(5, 1'b1, 20, 1);
			ck(n >= m + 2, 1'b1);
			@(posedge clk);
			run <= 1'b0;
			repeat (30) @(posedge clk);
		end
		summarize();
	end
endmodule

`default_nettype wire
